// File: src/ccs_pkg.sv
// Constants and types of the register bank
package ccs_pkg;

  // Register addresses
  localparam logic [6:0] ADDR_PULL_IN = 7'h10;
  localparam logic [6:0] ADDR_ACCEPT = 7'h11;
  localparam logic [6:0] ADDR_MODE_CFG = 7'h12;
  localparam logic [6:0] ADDR_SWITCH_CFG = 7'h13;
  localparam logic [6:0] ADDR_PLL1_ACQ = 7'h14;
  localparam logic [6:0] ADDR_PLL1_TRK_LO = 7'h15;
  localparam logic [6:0] ADDR_PLL1_TRK_HI = 7'h16;
  localparam logic [6:0] ADDR_PLL2_BW = 7'h17;
  localparam logic [6:0] ADDR_LINK_STATUS = 7'h18;
  localparam logic [6:0] ADDR_CUST_ID = 7'h19;
  localparam logic [6:0] ADDR_FW_ID = 7'h1A;

  // Values after reset
  localparam logic [7:0] RST_PULL_IN = 8'h1E;
  localparam logic [7:0] RST_ACCEPT = 8'h1A;
  localparam logic [7:0] RST_MODE_CFG = 8'h00;
  localparam logic [7:0] RST_SWITCH_CFG = 8'h00;
  localparam logic [7:0] RST_PLL1_ACQ = 8'h64;
  localparam logic [7:0] RST_PLL1_TRK_LO = 8'h23;
  localparam logic [7:0] RST_PLL1_TRK_HI = 8'h01;
  localparam logic [7:0] RST_PLL2_BW = 8'h53;

  // Mode register fields
  localparam int MODE_SRC_BIT = 7;
  localparam int SLAVE_SEL_BIT = 6;
  localparam logic [7:0] MODE_CFG_MASK = 8'hCF;

  // Switching policy register fields
  localparam int AUTO_SW_BIT = 0;
  localparam int REVERT_BIT = 1;
  localparam int HIST_CLR_BIT = 2;
  localparam int SOFT_RST_BIT = 3;
  localparam int OFFSET_SEL_BIT = 4;
  localparam int BUILD_OUT_DIS_BIT = 5;
  localparam logic [7:0] SWITCH_CFG_MASK = 8'h33;

  // Serial link status codes
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_RX_OVERFLOW = 8'h02;
  localparam logic [7:0] STATUS_BAD_ADDR = 8'h03;
  localparam logic [7:0] STATUS_BAD_WRITE = 8'h04;

  // Mode codes
  localparam logic [3:0] MODE_FREE_RUN = 4'h0;
  localparam logic [3:0] MODE_HOLDOVER = 4'h3;
  localparam logic [3:0] MODE_LAST = 4'h7;

  // Synchroniser reset levels, select idles high
  localparam logic [6:0] SYNC_INIT = 7'h02;

  // Serial frame states
  typedef enum logic [1:0] {
    CCS_IDLE = 2'b00,
    CCS_ADDR = 2'b01,
    CCS_DATA = 2'b10,
    CCS_EXTRA = 2'b11
  } ccs_frame_t;

  // Operating mode classes
  typedef enum logic [1:0] {
    CCS_FREE = 2'b00,
    CCS_LOCK = 2'b01,
    CCS_HOLD = 2'b10
  } ccs_op_t;

endpackage

// File: src/ccs_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ccs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Pins in, filtered levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_q
);

  logic [W-1:0] s1_q; // First stage, read only by second
  logic [W-1:0] s2_q; // Second stage
  logic [W-1:0] s3_q; // Third stage

  // Shift chain
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only when stages two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        level_q[i] <= INIT[i];
      end else if (s2_q[i] == s3_q[i]) begin
        level_q[i] <= s2_q[i];
      end
    end
  end

endmodule
`default_nettype wire

// File: src/ccs_regs.sv
// Clock unit configuration and status registers
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RL1 - limits unsigned, half ppm per bit
// RL2 - reject outside pull-in window
// RL3 - usable only inside acceptance window
// RL4 - host keeps pull-in above acceptance
// RL5 - source bit low: mode from pins
// RL6 - source bit high: register mode code
// RL7 - decode mode codes
// RL8 - ignore bad codes, reserved bits
// RL9 - slave needs secondary clock
// RL10 - auto switch by priority
// RL11 - revertive selection
// RL12 - history clear erases holdover history
// RL13 - software reset bit resets module
// RL14 - offset ranking with auto switch
// RL15 - build-out disable
// RL16 - acquisition bandwidth in hertz
// RL17 - primary tracking codes decoded
// RL18 - secondary nibbles decoded
// RL19 - link status codes 0, 2, 3, 4
// RL20 - third byte means overflow
// RL21 - fixed identity registers
// RL22 - priority 15 best, 0 unused
// RL23 - top policy bits read zero
module ccs_regs #(
  parameter int NREF = 6,
  parameter logic [7:0] CUSTOMER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] FIRMWARE_ID = 8'hC3 // Arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Serial host port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_q,
  output logic spi_miso_oe_q,
  // Mode pins, secondary clock detect
  input wire logic mode_pin_a,
  input wire logic mode_pin_b,
  input wire logic mode_pin_c,
  input wire logic sec_clk_present,
  // Reference monitor, same clock
  input wire logic [NREF-1:0] ref_present,
  input wire logic [NREF*8-1:0] ref_offset,
  input wire logic [NREF*4-1:0] ref_priority,
  input wire logic [1:0] pll1_trk_stage,
  // Reference qualification
  output logic [NREF-1:0] ref_pullin_ok_q,
  output logic [NREF-1:0] ref_usable_q,
  // Mode and selection
  output logic [1:0] op_mode_q,
  output logic [3:0] mode_code_q,
  output logic [$clog2(NREF+1)-1:0] selected_ref_q,
  output logic slave_mode_q,
  output logic revertive_mode_q,
  output logic build_out_disable_q,
  output logic history_clear_q,
  output logic soft_reset_q,
  // Loop bandwidths
  output logic [7:0] pll1_acq_hz_q,
  output logic [14:0] pll1_trk_mhz_q,
  output logic [9:0] pll2_acq_hz_q,
  output logic [7:0] pll2_trk_hz_q
);

  localparam int SW = $clog2(NREF + 1);

  // Class of a mode code
  function automatic logic [1:0] mode_kind(input logic [3:0] c);
    if (c == ccs_pkg::MODE_FREE_RUN) begin
      mode_kind = ccs_pkg::CCS_FREE;
    end else if (c == ccs_pkg::MODE_HOLDOVER) begin
      mode_kind = ccs_pkg::CCS_HOLD;
    end else begin
      mode_kind = ccs_pkg::CCS_LOCK;
    end
  endfunction

  // Reference of a lock code
  function automatic logic [SW-1:0] lock_ref(input logic [3:0] c);
    if (c < ccs_pkg::MODE_HOLDOVER) begin
      lock_ref = SW'(c);
    end else begin
      lock_ref = SW'(c - 4'h1);
    end
  endfunction

  // Readable address check
  function automatic logic rd_ok(input logic [6:0] a);
    rd_ok = (a >= ccs_pkg::ADDR_PULL_IN) && (a <= ccs_pkg::ADDR_FW_ID);
  endfunction

  // Writable address check
  function automatic logic wr_ok(input logic [6:0] a);
    wr_ok = (a >= ccs_pkg::ADDR_PULL_IN) && (a <= ccs_pkg::ADDR_PLL2_BW);
  endfunction

  // Synchronised pins
  logic [6:0] pin_lv;
  logic sclk_lv, cs_n_lv, mosi_lv, sec_lv;
  logic sclk_prev_q; // Last sampled serial clock
  logic sclk_rise, sclk_fall;

  ccs_sync #(.W(7), .INIT(ccs_pkg::SYNC_INIT)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({sec_clk_present, mode_pin_c, mode_pin_b, mode_pin_a,
               spi_mosi, spi_cs_n, spi_sclk}),
    .level_q(pin_lv)
  );

  assign sclk_lv = pin_lv[0];
  assign cs_n_lv = pin_lv[1];
  assign mosi_lv = pin_lv[2];
  assign sec_lv = pin_lv[6];
  assign sclk_rise = sclk_lv && !sclk_prev_q;
  assign sclk_fall = !sclk_lv && sclk_prev_q;

  // Serial frame state
  ccs_pkg::ccs_frame_t frame_q;
  logic [2:0] bit_cnt_q; // Bits of current byte
  logic [7:0] shift_q; // Receive shifter
  logic [7:0] cmd_q; // Command byte: read flag, address
  logic [7:0] tx_q; // Transmit shifter
  logic [7:0] rx_byte, rd_data;
  logic byte_done, exec, wr_en, rd_en, overflow;

  // Configuration and status registers
  logic [7:0] pull_in_limit_q, acceptance_limit_q;
  logic [7:0] mode_config_q, switching_policy_config_q;
  logic [7:0] primary_tracking_bw_low_q, primary_tracking_bw_high_q;
  logic [7:0] secondary_pll_bw_q, serial_link_status_q;
  logic [3:0] mode_prev_q; // Mode code one cycle ago
  logic bad_value;

  assign rx_byte = {shift_q[6:0], mosi_lv};
  assign byte_done = sclk_rise && (bit_cnt_q == 3'h7) &&
                     (frame_q != ccs_pkg::CCS_IDLE);
  assign exec = byte_done && (frame_q == ccs_pkg::CCS_DATA);
  assign wr_en = exec && !cmd_q[7];
  assign rd_en = exec && cmd_q[7];
  // RL20 extra byte
  assign overflow = byte_done && (frame_q == ccs_pkg::CCS_EXTRA);
  // RL4 zero limits refused
  assign bad_value = (rx_byte == 8'h00) &&
                     ((cmd_q[6:0] == ccs_pkg::ADDR_PULL_IN) ||
                      (cmd_q[6:0] == ccs_pkg::ADDR_ACCEPT));

  // Serial clock edge history
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_lv;
    end
  end

  // Frame sequencing by bytes
  always_ff @(posedge ref_clk) begin
    if (!resetn || cs_n_lv) begin
      frame_q <= ccs_pkg::CCS_IDLE;
    end else begin
      case (frame_q)
        ccs_pkg::CCS_IDLE: begin
          frame_q <= ccs_pkg::CCS_ADDR;
        end
        ccs_pkg::CCS_ADDR: begin
          if (byte_done) begin
            frame_q <= ccs_pkg::CCS_DATA;
          end
        end
        ccs_pkg::CCS_DATA: begin
          if (byte_done) begin
            frame_q <= ccs_pkg::CCS_EXTRA;
          end
        end
        ccs_pkg::CCS_EXTRA: begin
          frame_q <= ccs_pkg::CCS_EXTRA;
        end
        default: begin
          frame_q <= ccs_pkg::CCS_IDLE;
        end
      endcase
    end
  end

  // Receive shifter and bit count
  always_ff @(posedge ref_clk) begin
    if (!resetn || cs_n_lv || frame_q == ccs_pkg::CCS_IDLE) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
    end else if (sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= rx_byte;
    end
  end

  // Command byte capture
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cmd_q <= 8'h00;
    end else if (byte_done && frame_q == ccs_pkg::CCS_ADDR) begin
      cmd_q <= rx_byte;
    end
  end

  // Read data of addressed register
  always_comb begin
    case (rx_byte[6:0])
      ccs_pkg::ADDR_PULL_IN: rd_data = pull_in_limit_q;
      ccs_pkg::ADDR_ACCEPT: rd_data = acceptance_limit_q;
      ccs_pkg::ADDR_MODE_CFG: rd_data = mode_config_q;
      // RL23 upper bits zero
      ccs_pkg::ADDR_SWITCH_CFG: rd_data = switching_policy_config_q;
      ccs_pkg::ADDR_PLL1_ACQ: rd_data = pll1_acq_hz_q;
      ccs_pkg::ADDR_PLL1_TRK_LO: rd_data = primary_tracking_bw_low_q;
      ccs_pkg::ADDR_PLL1_TRK_HI: rd_data = primary_tracking_bw_high_q;
      ccs_pkg::ADDR_PLL2_BW: rd_data = secondary_pll_bw_q;
      ccs_pkg::ADDR_LINK_STATUS: rd_data = serial_link_status_q;
      // RL21 fixed identity
      ccs_pkg::ADDR_CUST_ID: rd_data = CUSTOMER_ID;
      ccs_pkg::ADDR_FW_ID: rd_data = FIRMWARE_ID;
      default: rd_data = 8'h00;
    endcase
  end

  // Transmit shifter on falling serial clock
  always_ff @(posedge ref_clk) begin
    if (!resetn || cs_n_lv) begin
      tx_q <= 8'h00;
      spi_miso_q <= 1'b0;
    end else if (byte_done && frame_q == ccs_pkg::CCS_ADDR) begin
      tx_q <= (rx_byte[7] && rd_ok(rx_byte[6:0])) ? rd_data : 8'h00;
    end else if (sclk_fall) begin
      spi_miso_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // Data line driven while selected
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      spi_miso_oe_q <= 1'b0;
    end else begin
      spi_miso_oe_q <= !cs_n_lv;
    end
  end

  // Writable registers, soft reset restores
  always_ff @(posedge ref_clk) begin
    if (!resetn || soft_reset_q) begin
      pull_in_limit_q <= ccs_pkg::RST_PULL_IN;
      acceptance_limit_q <= ccs_pkg::RST_ACCEPT;
      mode_config_q <= ccs_pkg::RST_MODE_CFG;
      switching_policy_config_q <= ccs_pkg::RST_SWITCH_CFG;
      pll1_acq_hz_q <= ccs_pkg::RST_PLL1_ACQ;
      primary_tracking_bw_low_q <= ccs_pkg::RST_PLL1_TRK_LO;
      primary_tracking_bw_high_q <= ccs_pkg::RST_PLL1_TRK_HI;
      secondary_pll_bw_q <= ccs_pkg::RST_PLL2_BW;
    end else if (wr_en && wr_ok(cmd_q[6:0]) && !bad_value) begin
      case (cmd_q[6:0])
        ccs_pkg::ADDR_PULL_IN: pull_in_limit_q <= rx_byte;
        ccs_pkg::ADDR_ACCEPT: acceptance_limit_q <= rx_byte;
        // RL8 reserved bits dropped
        ccs_pkg::ADDR_MODE_CFG: begin
          mode_config_q <= rx_byte & ccs_pkg::MODE_CFG_MASK;
        end
        // RL23 top bits dropped
        ccs_pkg::ADDR_SWITCH_CFG: begin
          switching_policy_config_q <= rx_byte & ccs_pkg::SWITCH_CFG_MASK;
        end
        // RL16 hertz value
        ccs_pkg::ADDR_PLL1_ACQ: pll1_acq_hz_q <= rx_byte;
        ccs_pkg::ADDR_PLL1_TRK_LO: primary_tracking_bw_low_q <= rx_byte;
        ccs_pkg::ADDR_PLL1_TRK_HI: primary_tracking_bw_high_q <= rx_byte;
        ccs_pkg::ADDR_PLL2_BW: secondary_pll_bw_q <= rx_byte;
        default: begin
        end
      endcase
    end
  end

  // Self-clearing action pulses
  always_ff @(posedge ref_clk) begin
    if (!resetn || soft_reset_q) begin
      history_clear_q <= 1'b0;
      soft_reset_q <= 1'b0;
    end else begin
      // RL12 history erase
      history_clear_q <= wr_en && rx_byte[ccs_pkg::HIST_CLR_BIT] &&
                         (cmd_q[6:0] == ccs_pkg::ADDR_SWITCH_CFG);
      // RL13 internal reset
      soft_reset_q <= wr_en && rx_byte[ccs_pkg::SOFT_RST_BIT] &&
                      (cmd_q[6:0] == ccs_pkg::ADDR_SWITCH_CFG);
    end
  end

  // Serial link status
  always_ff @(posedge ref_clk) begin
    if (!resetn || soft_reset_q) begin
      serial_link_status_q <= ccs_pkg::STATUS_OK;
    // RL20 overflow code
    end else if (overflow) begin
      serial_link_status_q <= ccs_pkg::STATUS_RX_OVERFLOW;
    // RL19 read outcome
    end else if (rd_en) begin
      if (!rd_ok(cmd_q[6:0])) begin
        serial_link_status_q <= ccs_pkg::STATUS_BAD_ADDR;
      end else if (cmd_q[6:0] != ccs_pkg::ADDR_LINK_STATUS) begin
        serial_link_status_q <= ccs_pkg::STATUS_OK;
      end
    // RL19 write outcome
    end else if (wr_en) begin
      if (!wr_ok(cmd_q[6:0]) || bad_value) begin
        serial_link_status_q <= ccs_pkg::STATUS_BAD_WRITE;
      end else begin
        serial_link_status_q <= ccs_pkg::STATUS_OK;
      end
    end
  end

  // Effective mode code
  logic [3:0] mode_cand;
  // RL5 pins or RL6 register
  assign mode_cand = mode_config_q[ccs_pkg::MODE_SRC_BIT] ?
                     mode_config_q[3:0] :
                     {1'b0, pin_lv[5], pin_lv[4], pin_lv[3]};

  always_ff @(posedge ref_clk) begin
    if (!resetn || soft_reset_q) begin
      mode_code_q <= ccs_pkg::MODE_FREE_RUN;
      mode_prev_q <= ccs_pkg::MODE_FREE_RUN;
      op_mode_q <= ccs_pkg::CCS_FREE;
    end else begin
      // RL8 unsupported code ignored
      if (mode_cand <= ccs_pkg::MODE_LAST) begin
        mode_code_q <= mode_cand;
      end
      mode_prev_q <= mode_code_q;
      // RL7 mode decode
      op_mode_q <= mode_kind(mode_code_q);
    end
  end

  // Policy outputs
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      slave_mode_q <= 1'b0;
      revertive_mode_q <= 1'b0;
      build_out_disable_q <= 1'b0;
    end else begin
      // RL9 slave needs secondary clock
      slave_mode_q <= mode_config_q[ccs_pkg::SLAVE_SEL_BIT] && sec_lv;
      // RL11 revertive mode
      revertive_mode_q <= switching_policy_config_q[ccs_pkg::REVERT_BIT];
      // RL15 build-out off
      build_out_disable_q <=
        switching_policy_config_q[ccs_pkg::BUILD_OUT_DIS_BIT];
    end
  end

  // Per-reference qualification and ranking
  logic [7:0] abs_off [NREF];
  logic [7:0] score [NREF];
  logic auto_sw, by_offset;
  assign auto_sw = switching_policy_config_q[ccs_pkg::AUTO_SW_BIT];
  // RL14 offset ranking needs auto switch
  assign by_offset = auto_sw &&
                     switching_policy_config_q[ccs_pkg::OFFSET_SEL_BIT];

  for (genvar i = 0; i < NREF; i++) begin : g_ref
    logic [7:0] off;
    logic [3:0] prio;
    assign off = ref_offset[i*8 +: 8];
    assign prio = ref_priority[i*4 +: 4];
    // Magnitude in half ppm
    assign abs_off[i] = off[7] ? 8'(-off) : off;
    // RL14 small offset or RL22 high code first
    assign score[i] = by_offset ? ~abs_off[i] : {4'h0, prio};

    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        ref_pullin_ok_q[i] <= 1'b0;
        ref_usable_q[i] <= 1'b0;
      end else begin
        // RL1 RL2 pull-in window
        ref_pullin_ok_q[i] <= ref_present[i] &&
                              (abs_off[i] <= pull_in_limit_q);
        // RL3 RL22 acceptance window, prio 0 unused
        ref_usable_q[i] <= ref_present[i] && (prio != 4'h0) &&
                           (abs_off[i] <= acceptance_limit_q) &&
                           (abs_off[i] <= pull_in_limit_q);
      end
    end
  end

  // Best candidate and current reference
  logic [SW-1:0] best_idx;
  logic [7:0] best_sc, cur_sc;
  logic cur_ok;

  always_comb begin
    best_idx = '0;
    best_sc = 8'h00;
    cur_sc = 8'h00;
    cur_ok = 1'b0;
    for (int i = 0; i < NREF; i++) begin
      if (ref_usable_q[i] && (best_idx == '0 || score[i] > best_sc)) begin
        best_idx = SW'(i + 1);
        best_sc = score[i];
      end
      if (selected_ref_q == SW'(i + 1)) begin
        cur_sc = score[i];
        cur_ok = ref_usable_q[i];
      end
    end
  end

  // Reference in use
  always_ff @(posedge ref_clk) begin
    if (!resetn || soft_reset_q) begin
      selected_ref_q <= '0;
    end else if (mode_kind(mode_code_q) != ccs_pkg::CCS_LOCK) begin
      selected_ref_q <= '0;
    end else if (mode_code_q != mode_prev_q) begin
      selected_ref_q <= lock_ref(mode_code_q);
    // RL10 switch on loss if enabled
    end else if (!cur_ok && auto_sw) begin
      selected_ref_q <= best_idx;
    // RL11 revert to a better reference
    end else if (cur_ok && auto_sw && revertive_mode_q &&
                 best_idx != '0 && best_sc > cur_sc) begin
      selected_ref_q <= best_idx;
    end
  end

  // Bandwidth decoding
  logic [15:0] trk_all;
  logic [3:0] trk_code;
  logic [3:0] acq2, trk2;
  assign trk_all = {primary_tracking_bw_high_q, primary_tracking_bw_low_q};
  assign trk_code = trk_all[pll1_trk_stage*4 +: 4];
  assign acq2 = secondary_pll_bw_q[3:0];
  assign trk2 = secondary_pll_bw_q[7:4];

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pll1_trk_mhz_q <= 15'h0000;
      pll2_acq_hz_q <= 10'h000;
      pll2_trk_hz_q <= 8'h00;
    end else begin
      // RL17 tracking in millihertz
      case (trk_code)
        4'h1: pll1_trk_mhz_q <= 15'h0001;
        4'h2: pll1_trk_mhz_q <= 15'h000A;
        4'h3: pll1_trk_mhz_q <= 15'h0064;
        4'h4: pll1_trk_mhz_q <= 15'h03E8;
        4'h5: pll1_trk_mhz_q <= 15'h07D0;
        4'h6: pll1_trk_mhz_q <= 15'h0BB8;
        4'h7: pll1_trk_mhz_q <= 15'h2710;
        4'h8: pll1_trk_mhz_q <= 15'h4E20;
        default: pll1_trk_mhz_q <= 15'h0000;
      endcase
      // RL18 secondary acquisition
      if (acq2 <= 4'hA) begin
        pll2_acq_hz_q <= 10'(acq2 * 4'hA);
      end else begin
        pll2_acq_hz_q <= 10'((acq2 - 4'h9) * 7'h64);
      end
      // RL18 secondary tracking
      case (trk2)
        4'h0: pll2_trk_hz_q <= 8'h00;
        4'h1: pll2_trk_hz_q <= 8'h03;
        4'h2: pll2_trk_hz_q <= 8'h05;
        4'hA, 4'hB, 4'hC, 4'hD: pll2_trk_hz_q <= 8'((trk2 - 4'h5) * 4'hA);
        4'hE: pll2_trk_hz_q <= 8'h64;
        4'hF: pll2_trk_hz_q <= 8'hC8;
        default: pll2_trk_hz_q <= 8'((trk2 - 4'h1) * 4'h5);
      endcase
    end
  end

endmodule
`default_nettype wire

// File: sim/ccs_host.sv
// Host-side serial port model for the register bank
`timescale 1ns/100ps
`default_nettype none
module ccs_host (
  // Clock
  input wire logic ref_clk,
  // Serial port
  input wire logic spi_miso_q,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  // Idle frame: select high, clock low
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Frame of n bytes, h stretches each level
  task automatic xfer(input logic [7:0] b0, b1, input int n, h,
      output logic [7:0] rd);
    logic [23:0] sh = {b0, b1, 8'hA5};
    rd = 8'h00;
    @(posedge ref_clk);
    spi_cs_n <= 1'b0;
    repeat (6 + h) @(posedge ref_clk);
    for (int i = 0; i < 8 * n; i++) begin
      spi_mosi <= sh[23 - i];
      repeat (6 + h) @(posedge ref_clk);
      spi_sclk <= 1'b1;
      // Read data in byte two
      if (i >= 8 && i < 16) rd = {rd[6:0], spi_miso_q};
      repeat (5 + h) @(posedge ref_clk);
      spi_sclk <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    spi_cs_n <= 1'b1;
    // Released line flips
    spi_mosi <= ~spi_mosi;
    repeat (10) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// File: sim/ccs_regs_sva.sv
// Port checks of the register bank
`timescale 1ns/100ps
`default_nettype none
module ccs_regs_sva #(parameter int NREF = 6) (
  // Clock, reset, inputs
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sec_clk_present,
  input wire logic [NREF-1:0] ref_present,
  // Outputs
  input wire logic [NREF-1:0] ref_pullin_ok_q,
  input wire logic [NREF-1:0] ref_usable_q,
  input wire logic [1:0] op_mode_q,
  input wire logic [3:0] mode_code_q,
  input wire logic slave_mode_q,
  input wire logic history_clear_q,
  input wire logic soft_reset_q,
  input wire logic [7:0] pll1_acq_hz_q,
  input wire logic [14:0] pll1_trk_mhz_q,
  input wire logic [9:0] pll2_acq_hz_q
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // Mode class of a code
  function automatic logic [1:0] cls(input logic [3:0] c);
    return c == 4'h0 ? 2'h0 : c == 4'h3 ? 2'h2 : 2'h1;
  endfunction
  a_mode_class: assert property (
    !soft_reset_q |=> op_mode_q == cls($past(mode_code_q)))
    else $error("mode class wrong");
  a_code_range: assert property (
    mode_code_q <= 4'h7) else $error("code out of range");
  a_slave_gate: assert property (
    !sec_clk_present [*7] |=> !slave_mode_q) else $error("slave no clock");
  a_hist_pulse: assert property (
    history_clear_q |=> !history_clear_q) else $error("clear held");
  a_soft_defaults: assert property (
    soft_reset_q |=> pll1_acq_hz_q == 8'h64) else $error("no defaults");
  a_usable_inside: assert property (
    (ref_usable_q & ~ref_pullin_ok_q) == '0) else $error("usable outside");
  a_absent_reject: assert property (
    (ref_pullin_ok_q & ~$past(ref_present)) == '0)
    else $error("absent ref accepted");
  a_trk_legal: assert property (
    pll1_trk_mhz_q inside {15'h0,15'h1,15'hA,15'h64,15'h3E8,15'h7D0,
    15'hBB8,15'h2710,15'h4E20}) else $error("bad tracking");
  a_acq2_legal: assert property (
    pll2_acq_hz_q <= 10'h258 && pll2_acq_hz_q % 10'hA == 10'h0)
    else $error("bad acquisition");
  // Main scenarios reached
  c_soft: cover property (soft_reset_q);
  c_slave: cover property (slave_mode_q);
  c_hold: cover property (op_mode_q == 2'h2);
endmodule
bind ccs_regs ccs_regs_sva #(.NREF(NREF)) u_sva (.*);
`default_nettype wire

// File: sim/tb_clock_unit_config_status_regs.sv
// Bench for the clock unit register bank
`timescale 1ns/100ps
`default_nettype none
module tb_clock_unit_config_status_regs;
  localparam logic [7:0] CUST = 8'h5A; // Arbitrary value
  localparam logic [7:0] FWID = 8'hC3; // Arbitrary value
  logic ref_clk = 1'b0;
  logic resetn, spi_sclk, spi_cs_n, spi_mosi, spi_miso_q, spi_miso_oe_q;
  logic mode_pin_a, mode_pin_b, mode_pin_c, sec_clk_present;
  logic [5:0] ref_present, ref_pullin_ok_q, ref_usable_q;
  logic [47:0] ref_offset;
  logic [23:0] ref_priority;
  logic [1:0] pll1_trk_stage, op_mode_q;
  logic [3:0] mode_code_q;
  logic [2:0] selected_ref_q;
  logic slave_mode_q, revertive_mode_q, build_out_disable_q;
  logic history_clear_q, soft_reset_q;
  logic [7:0] pll1_acq_hz_q, pll2_trk_hz_q, rd;
  logic [14:0] pll1_trk_mhz_q;
  logic [9:0] pll2_acq_hz_q;
  logic [31:0] x = 32'h23;
  int bad_count = 0, comparisons = 0;
  int st, ms;
  // Register model by address - 0x10
  int mdl[8];
  int dflt[8] = '{8'h1E,8'h1A,0,0,8'h64,8'h23,8'h01,8'h53};
  int msk[8] = '{8'hFF,8'hFF,8'hCF,8'h33,8'hFF,8'hFF,8'hFF,8'hFF};
  // Bandwidths, mHz and Hz
  int tk[16] = '{0,1,10,100,1000,2000,3000,10000,20000,0,0,0,0,0,0,0};
  int t2[16] = '{0,3,5,10,15,20,25,30,35,40,50,60,70,80,100,200};
  ccs_regs #(.CUSTOMER_ID(CUST), .FIRMWARE_ID(FWID)) DUT (.*);
  ccs_host host (.*);
  always #2.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s exp %0h got %0h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic mreset();
    mdl = dflt;
    st = 0;
  endtask
  // Write; bad address or zero limit refused
  task automatic wr(logic [6:0] a, logic [7:0] d);
    host.xfer({1'b0, a}, d, 2, rnd() % 3, rd);
    if (a >= 7'h10 && a <= 7'h17 && !(a <= 7'h11 && d == 8'h00)) begin
      mdl[a - 7'h10] = d & msk[a - 7'h10];
      st = 0;
      if (a == 7'h13 && d[3]) mreset();
    end else st = 4;
  endtask
  task automatic rdc(logic [6:0] a);
    int e;
    host.xfer({1'b1, a}, 8'h00, 2, rnd() % 3, rd);
    case (a)
      7'h18: e = st;
      7'h19: e = CUST;
      7'h1A: e = FWID;
      default: e = (a >= 7'h10 && a < 7'h18) ? mdl[a - 7'h10] : 0;
    endcase
    chk($sformatf("reg %0h", a), rd, e);
    if (a < 7'h10 || a > 7'h1A) st = 3;
    else if (a != 7'h18) st = 0;
  endtask
  task automatic dec();
    int c;
    c = mdl[7] & 15;
    chk("acq2", pll2_acq_hz_q, c <= 10 ? 10 * c : 100 * (c - 9));
    chk("trk2", pll2_trk_hz_q, t2[mdl[7] >> 4]);
    chk("acq1", pll1_acq_hz_q, mdl[4]);
    chk("trk1", pll1_trk_mhz_q, tk[mdl[5] & 15]);
  endtask
  // Windows and selection
  task automatic qual(bit fo);
    logic [5:0] ep, eu;
    int ab[6];
    int bi = 0;
    for (int i = 0; i < 6; i++) begin
      ab[i] = $signed(ref_offset[8*i +: 8]);
      if (ab[i] < 0) ab[i] = -ab[i];
      ep[i] = ref_present[i] && ab[i] <= mdl[0];
      eu[i] = ep[i] && ref_priority[4*i +: 4] != 4'h0 && ab[i] <= mdl[1];
      if (eu[i] && (bi == 0 || (fo ? ab[i] < ab[bi-1] :
          ref_priority[4*i +: 4] > ref_priority[4*(bi-1) +: 4]))) bi = i + 1;
    end
    if (ms == 0 || !eu[ms-1]) ms = bi;
    chk("pullin", ref_pullin_ok_q, ep);
    chk("usable", ref_usable_q, eu);
    chk("selected", selected_ref_q, ms);
  endtask
  initial begin
    logic [6:0] a;
    resetn = 1'b0;
    {mode_pin_c, mode_pin_b, mode_pin_a, sec_clk_present} = 4'h0;
    {ref_present, ref_offset, ref_priority, pll1_trk_stage} = '0;
    mreset();
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    for (int i = 16; i < 28; i++) rdc(7'(i));
    rdc(7'h18);
    for (int s = 3; s >= 0; s--) begin
      pll1_trk_stage <= 2'(s);
      repeat (4) @(posedge ref_clk);
      chk("stage", pll1_trk_mhz_q, tk[(mdl[5+s/2] >> 4*(s%2)) & 15]);
    end
    dec();
    for (int c = 0; c < 8; c++) begin
      wr(7'h12, 8'h80 | 8'(c));
      chk("code", mode_code_q, c);
      chk("class", op_mode_q, c == 0 ? 0 : c == 3 ? 2 : 1);
      if (c == 1 || c == 4) chk("sel", selected_ref_q, c == 1 ? 1 : 3);
    end
    wr(7'h12, 8'h8E);
    chk("code", mode_code_q, 7);
    rdc(7'h12);
    wr(7'h12, 8'h40);
    {mode_pin_c, mode_pin_b, mode_pin_a, sec_clk_present} <= 4'hB;
    repeat (12) @(posedge ref_clk);
    chk("pins", mode_code_q, 5);
    chk("slave", slave_mode_q, 1);
    sec_clk_present <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk("slave", slave_mode_q, 0);
    wr(7'h13, 8'hE6);
    chk("revert", revertive_mode_q, 1);
    chk("build-out", build_out_disable_q, 1);
    rdc(7'h13);
    wr(7'h10, 8'h28);
    wr(7'h11, 8'h14);
    wr(7'h13, 8'h01);
    wr(7'h12, 8'h81);
    ms = 0;
    for (int i = 0; i < 30; i++) begin
      if (i == 15) wr(7'h13, 8'h11);
      ref_present <= 6'(rnd() | rnd());
      ref_priority <= 24'(rnd());
      for (int j = 0; j < 6; j++) ref_offset[8*j +: 8] <= 8'(rnd() % 96 - 48);
      repeat (4) @(posedge ref_clk);
      qual(i >= 15);
    end
    for (int i = 0; i < 20; i++) begin
      a = 7'h12 + 7'(rnd() % 6);
      wr(a, 8'(rnd()));
      rdc(a);
      dec();
    end
    wr(7'h10, 8'h00);
    rdc(7'h18);
    wr(7'h1A, 8'h11);
    rdc(7'h18);
    host.xfer(8'h94, 8'h00, 3, 0, rd);
    st = 2;
    rdc(7'h18);
    wr(7'h14, 8'h11);
    wr(7'h13, 8'h08);
    rdc(7'h14);
    dec();
    report_and_stop();
  end
endmodule
`default_nettype wire
